// ---- hw/mise_map.vh ----
// constants for the instruction subset executor: opcodes, phases, reset values
// assumes a 16-bit instruction word and a 12-bit data file address space
`ifndef MISE_MAP_VH
`define MISE_MAP_VH

// opcode match values, compared against the top bits of the instruction
`define MISE_OP_OR_LIT       8'h09
`define MISE_OP_SUB_LIT      8'h08
`define MISE_OP_OR_REG       6'h04
`define MISE_OP_SUB_REG      6'h17
`define MISE_OP_CLR_REG      7'h35
`define MISE_OP_REL_CALL     5'h1b
`define MISE_OP_WDT_CLEAR    16'h0004
`define MISE_OP_SOFT_RESET   16'h00ff

// instruction field positions
`define MISE_DEST_BIT        9
`define MISE_ACCESS_BIT      8

// four clock phases make one instruction cycle
`define MISE_Q1              2'h0
`define MISE_Q2              2'h1
`define MISE_Q3              2'h2
`define MISE_Q4              2'h3

// addressing
`define MISE_ACCESS_SPLIT    8'h80
`define MISE_ACCESS_HI_BANK  4'hf
`define MISE_INDEX_LIMIT     8'h5f

// reset values
`define MISE_RST_W           8'h00
`define MISE_RST_STATUS_TO   1'b1
`define MISE_RST_STATUS_PD   1'b1
`define MISE_RST_PC          21'h000000

`endif

// ---- hw/mise_addr_former.v ----
// file address former for byte-oriented register opcodes
// assumes bank select and index base are stable for the whole instruction cycle
`timescale 1ns/1ps
`default_nettype none
`include "mise_map.vh"

module mise_addr_former (
  input  wire [7:0]  f_operand,
  input  wire        access,
  input  wire [3:0]  bank_select_register,
  input  wire        ext_set_en,
  input  wire [11:0] index_base,
  output reg  [11:0] file_addr
);

  // access bit low picks the fixed access bank, or indexed offset in extended mode for operands up to 5Fh
  always @* begin
    if (access) begin
      file_addr = {bank_select_register, f_operand};
    end else if (ext_set_en && (f_operand <= `MISE_INDEX_LIMIT)) begin
      file_addr = index_base + {4'h0, f_operand};
    end else if (f_operand < `MISE_ACCESS_SPLIT) begin
      file_addr = {4'h0, f_operand};
    end else begin
      file_addr = {`MISE_ACCESS_HI_BANK, f_operand};
    end
  end

endmodule // mise_addr_former
`default_nettype wire

// ---- hw/mise_core.v ----
// instruction subset executor: or, subtract, relative call, clear, watchdog clear, soft reset
// assumes INSTR is valid for PROG_ADDR at phase Q1 and FILE_RDATA answers FILE_RE one clock later
// assumes the return stack, watchdog and file memory sit outside and act on the one-clock pulses
// all outputs are registered; pulses last one clock, levels hold until the next result
// a soft reset pulse restarts every register here except the two status bits
`timescale 1ns/1ps
`default_nettype none
`include "mise_map.vh"

// Operation
// - literal or: accumulator ORed with immediate into accumulator, only N and Z change.
// - register or: accumulator ORed with file register, N and Z change, one cycle.
// - register or: destination bit 0 writes accumulator, 1 writes file register.
// - access bit 0 selects the fixed access bank.
// - access bit 1 forms address from bank select register and operand.
// - extended mode, access 0, operand up to 5Fh uses indexed literal offset.
// - relative call pushes next address, jumps to next plus twice signed offset.
// - software reset acts as a master-clear reset of all affected state.
// - subtract from literal: immediate minus accumulator into accumulator, all five flags.
// - register subtract: file minus accumulator, destination 0 stores accumulator.
// - register subtract destination 1 writes file register, all five flags change.
// - register clear writes 00h to addressed register and sets zero flag.
// - watchdog clear zeroes counter and postscaler, sets timeout and sleep bits.
module mise_core #(
  parameter PC_W = 21
) (
  input  wire            CLK_SYS,
  input  wire            RST_N,
  input  wire [15:0]     INSTR,
  input  wire            INSTR_VALID,
  input  wire [3:0]      BANK_SELECT,
  input  wire            EXT_SET_EN,
  input  wire [11:0]     INDEX_BASE,
  input  wire [7:0]      FILE_RDATA,
  output reg  [PC_W-1:0] PROG_ADDR,
  output reg  [11:0]     FILE_ADDR,
  output reg             FILE_RE,
  output reg             FILE_WE,
  output reg  [7:0]      FILE_WDATA,
  output reg  [7:0]      W_REG,
  output reg             FLAG_N,
  output reg             FLAG_OV,
  output reg             FLAG_Z,
  output reg             FLAG_DC,
  output reg             FLAG_C,
  output reg             STATUS_TO,
  output reg             STATUS_PD,
  output reg             WDT_CLEAR,
  output reg             STACK_PUSH,
  output reg  [PC_W-1:0] STACK_DATA,
  output reg             SOFT_RESET,
  output reg             CYCLE_END
);

  // subtract a - b as a + ~b + 1; returns {c, dc, ov, result}
  function [10:0] sub_flags;
    input [7:0] a;
    input [7:0] b;
    reg   [8:0] full;
    reg   [4:0] low;
    begin
      full      = {1'b0, a} + {1'b0, ~b} + 9'h001;
      low       = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      sub_flags = {full[8], low[4], (a[7] != b[7]) && (full[7] != a[7]), full[7:0]};
    end
  endfunction

  // zero test used by the or and subtract result paths; clear sets the zero flag directly
  function is_zero;
    input [7:0] v;
    begin
      is_zero = (v == 8'h00);
    end
  endfunction

  // inclusive or of accumulator and operand, shared by both or opcodes
  function [7:0] or_result;
    input [7:0] a;
    input [7:0] b;
    begin
      or_result = a | b;
    end
  endfunction

  reg  [1:0]      phase;
  reg  [15:0]     ir;
  reg             idle;       // cycle carries no instruction
  reg             flush;      // next cycle discarded after a call
  reg  [7:0]      operand;
  reg  [10:0]     sub_res;
  wire [11:0]     formed_addr;

  // phase edges that do work; idle cycles still step through all four
  wire            at_q1      = (phase == `MISE_Q1);
  wire            at_q2_live = (phase == `MISE_Q2) && !idle;
  wire            at_q3      = (phase == `MISE_Q3);
  wire            at_q4      = (phase == `MISE_Q4);
  wire            at_q4_live = at_q4 && !idle;

  // decode of the latched instruction
  wire is_or_lit  = (ir[15:8] == `MISE_OP_OR_LIT);
  wire is_sub_lit = (ir[15:8] == `MISE_OP_SUB_LIT);
  wire is_or_reg  = (ir[15:10] == `MISE_OP_OR_REG);
  wire is_sub_reg = (ir[15:10] == `MISE_OP_SUB_REG);
  wire is_clr_reg = (ir[15:9] == `MISE_OP_CLR_REG);
  wire is_relative_call_opcode   = (ir[15:11] == `MISE_OP_REL_CALL);
  wire is_wdt_clr = (ir == `MISE_OP_WDT_CLEAR);
  wire is_sreset  = (ir == `MISE_OP_SOFT_RESET);
  wire uses_file  = is_or_reg | is_sub_reg | is_clr_reg;
  wire dest_file  = ir[`MISE_DEST_BIT];

  // call target: next address plus twice the sign-extended 11-bit offset
  wire [PC_W-1:0] next_pc    = PROG_ADDR + {{(PC_W-2){1'b0}}, 2'h2};
  wire [PC_W-1:0] rel_offset = {{(PC_W-12){ir[10]}}, ir[10:0], 1'b0};
  wire [PC_W-1:0] call_target = next_pc + rel_offset;

  mise_addr_former u_addr (
    .f_operand            (ir[7:0]),
    .access               (ir[`MISE_ACCESS_BIT]),
    .bank_select_register (BANK_SELECT),
    .ext_set_en           (EXT_SET_EN),
    .index_base           (INDEX_BASE),
    .file_addr            (formed_addr)
  );

  // phase counter and instruction latch; a soft reset restarts at Q1
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      phase <= `MISE_Q1;
      ir    <= 16'h0000;
      idle  <= 1'b1;
      flush <= 1'b0;
    end else if (SOFT_RESET) begin
      phase <= `MISE_Q1;
      ir    <= 16'h0000;
      idle  <= 1'b1;
      flush <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      if (at_q1) begin
        // an idle second cycle follows each call while the target is fetched
        ir    <= INSTR;
        idle  <= flush | ~INSTR_VALID;
        flush <= 1'b0;
      end else if (at_q4_live && is_relative_call_opcode) begin
        flush <= 1'b1;
      end
    end
  end

  // Q2: present the file address and read strobe
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      FILE_ADDR <= 12'h000;
      FILE_RE   <= 1'b0;
    end else if (SOFT_RESET) begin
      FILE_ADDR <= 12'h000;
      FILE_RE   <= 1'b0;
    end else begin
      FILE_RE <= 1'b0;
      // clear needs the address only, no read
      if (at_q2_live && uses_file) begin
        FILE_ADDR <= formed_addr;
        FILE_RE   <= ~is_clr_reg;
      end
    end
  end

  // Q3: capture operand and precompute the subtraction
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      operand <= 8'h00;
      sub_res <= 11'h000;
    end else if (SOFT_RESET) begin
      operand <= 8'h00;
      sub_res <= 11'h000;
    end else if (at_q3) begin
      if (is_or_reg || is_sub_reg) begin
        operand <= FILE_RDATA;
        sub_res <= sub_flags(FILE_RDATA, W_REG);
      end else begin
        operand <= ir[7:0];
        sub_res <= sub_flags(ir[7:0], W_REG);
      end
    end
  end

  // Q4: accumulator, flags and file write-back
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      W_REG      <= `MISE_RST_W;
      FLAG_N     <= 1'b0;
      FLAG_OV    <= 1'b0;
      FLAG_Z     <= 1'b0;
      FLAG_DC    <= 1'b0;
      FLAG_C     <= 1'b0;
      FILE_WE    <= 1'b0;
      FILE_WDATA <= 8'h00;
      CYCLE_END  <= 1'b0;
    end else if (SOFT_RESET) begin
      // software reset returns master-clear state
      W_REG      <= `MISE_RST_W;
      FLAG_N     <= 1'b0;
      FLAG_OV    <= 1'b0;
      FLAG_Z     <= 1'b0;
      FLAG_DC    <= 1'b0;
      FLAG_C     <= 1'b0;
      FILE_WE    <= 1'b0;
      FILE_WDATA <= 8'h00;
      CYCLE_END  <= 1'b0;
    end else begin
      // the write strobe lasts one clock; the cycle end follows each Q4 edge
      FILE_WE   <= 1'b0;
      CYCLE_END <= at_q4;
      // results land only at the Q4 edge of a live cycle
      if (at_q4_live) begin
        if (is_or_lit) begin
          W_REG  <= or_result(W_REG, operand);
          FLAG_N <= W_REG[7] | operand[7];
          FLAG_Z <= is_zero(or_result(W_REG, operand));
        end else if (is_or_reg) begin
          if (dest_file) begin
            FILE_WE    <= 1'b1;
            FILE_WDATA <= or_result(W_REG, operand);
          end else begin
            W_REG <= or_result(W_REG, operand);
          end
          FLAG_N <= W_REG[7] | operand[7];
          FLAG_Z <= is_zero(or_result(W_REG, operand));
        end else if (is_sub_lit || is_sub_reg) begin
          if (is_sub_reg && dest_file) begin
            FILE_WE    <= 1'b1;
            FILE_WDATA <= sub_res[7:0];
          end else begin
            W_REG <= sub_res[7:0];
          end
          FLAG_C  <= sub_res[10];
          FLAG_DC <= sub_res[9];
          FLAG_OV <= sub_res[8];
          FLAG_N  <= sub_res[7];
          FLAG_Z  <= is_zero(sub_res[7:0]);
        end else if (is_clr_reg) begin
          FILE_WE    <= 1'b1;
          FILE_WDATA <= 8'h00;
          FLAG_Z     <= 1'b1;
        end
      end
    end
  end

  // Q4: program counter and return stack push
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      PROG_ADDR  <= `MISE_RST_PC;
      STACK_PUSH <= 1'b0;
      STACK_DATA <= {PC_W{1'b0}};
    end else if (SOFT_RESET) begin
      PROG_ADDR  <= `MISE_RST_PC;
      STACK_PUSH <= 1'b0;
      STACK_DATA <= {PC_W{1'b0}};
    end else begin
      STACK_PUSH <= 1'b0;
      if (at_q4_live) begin
        if (is_relative_call_opcode) begin
          STACK_PUSH <= 1'b1;
          STACK_DATA <= next_pc;
          PROG_ADDR  <= call_target;
        end else begin
          PROG_ADDR <= next_pc; // every other opcode, unknown ones too, steps by two
        end
      end
    end
  end

  // one-clock requests to the watchdog and to the reset logic of the chip
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      WDT_CLEAR  <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else if (SOFT_RESET) begin
      WDT_CLEAR  <= 1'b0;
      SOFT_RESET <= 1'b0;
    end else begin
      WDT_CLEAR  <= at_q4_live && is_wdt_clr;
      SOFT_RESET <= at_q4_live && is_sreset;
    end
  end

  // status bits set by watchdog clear; master-clear leaves them alone
  always @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      STATUS_TO <= `MISE_RST_STATUS_TO;
      STATUS_PD <= `MISE_RST_STATUS_PD;
    end else if ((phase == `MISE_Q4) && !idle && is_wdt_clr && !SOFT_RESET) begin
      STATUS_TO <= 1'b1;
      STATUS_PD <= 1'b1;
    end
  end

endmodule // mise_core
`default_nettype wire

// ---- verification/mise_core_assertions.sv ----
// timing and flag checker for the instruction subset executor
// assumes one clock domain, asynchronous active-low reset, four clocks per cycle
`timescale 1ns/1ps
`default_nettype none
module mise_core_assertions #(
  parameter PC_W = 21
) (
  input wire logic            CLK_SYS,
  input wire logic            RST_N,
  input wire logic [PC_W-1:0] PROG_ADDR,
  input wire logic            FILE_RE,
  input wire logic            FILE_WE,
  input wire logic [7:0]      FILE_WDATA,
  input wire logic [7:0]      W_REG,
  input wire logic            FLAG_N,
  input wire logic            FLAG_Z,
  input wire logic            FLAG_C,
  input wire logic            STATUS_TO,
  input wire logic            STATUS_PD,
  input wire logic            WDT_CLEAR,
  input wire logic            STACK_PUSH,
  input wire logic            SOFT_RESET,
  input wire logic            CYCLE_END
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  // a read is answered in the same instruction cycle
  a_re_then_end: assert property (FILE_RE |-> ##2 CYCLE_END)
    else $error("file read not closed two clocks later");
  a_write_at_end: assert property (FILE_WE |-> CYCLE_END)
    else $error("file write outside the last phase");
  a_end_spacing: assert property (CYCLE_END |=> !CYCLE_END[*3])
    else $error("instruction cycle shorter than four clocks");
  // the cycle after a call is idle, program address holds
  a_call_flush: assert property (STACK_PUSH |=> $stable(PROG_ADDR)[*4])
    else $error("program address moved during flush cycle");
  // a write with no read before it is a clear
  a_clear_zero: assert property (FILE_WE && !$past(FILE_RE, 2) |-> FILE_WDATA == 8'h00 && FLAG_Z)
    else $error("clear wrote nonzero or left zero flag low");
  a_zero_follows: assert property (FILE_WE |-> FLAG_Z == (FILE_WDATA == 8'h00))
    else $error("zero flag disagrees with written result");
  a_neg_follows: assert property (FILE_WE && $past(FILE_RE, 2) |-> FLAG_N == FILE_WDATA[7])
    else $error("negative flag disagrees with result bit 7");
  a_wdt_status: assert property (WDT_CLEAR |-> STATUS_TO && STATUS_PD && CYCLE_END)
    else $error("watchdog clear without status bits set");
  a_soft_reset: assert property (SOFT_RESET |=> W_REG == 8'h00 && PROG_ADDR == '0 && !FLAG_C)
    else $error("software reset left state behind");
endmodule // mise_core_assertions

bind mise_core mise_core_assertions #(.PC_W(PC_W)) u_chk (
  .CLK_SYS(CLK_SYS), .RST_N(RST_N), .PROG_ADDR(PROG_ADDR), .FILE_RE(FILE_RE),
  .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .W_REG(W_REG), .FLAG_N(FLAG_N),
  .FLAG_Z(FLAG_Z), .FLAG_C(FLAG_C), .STATUS_TO(STATUS_TO), .STATUS_PD(STATUS_PD),
  .WDT_CLEAR(WDT_CLEAR), .STACK_PUSH(STACK_PUSH), .SOFT_RESET(SOFT_RESET), .CYCLE_END(CYCLE_END)
);
`default_nettype wire

// ---- verification/mise_core_test.sv ----
// self-checking bench for the instruction subset executor
// assumes the first edge after reset release is a Q1 edge, four clocks per cycle
`timescale 1ns/1ps
`default_nettype none
`include "mise_map.vh"
module mise_core_test;
  logic        CLK_SYS = 1'b0;
  logic        RST_N = 1'b0;
  logic [15:0] INSTR = 16'h0000;
  logic        INSTR_VALID = 1'b0;
  logic [3:0]  BANK_SELECT = 4'h0;
  logic        EXT_SET_EN = 1'b0;
  logic [11:0] INDEX_BASE = 12'h000;
  logic [7:0]  FILE_RDATA = 8'h00;
  wire  [20:0] PROG_ADDR, STACK_DATA;
  wire  [11:0] FILE_ADDR;
  wire  [7:0]  FILE_WDATA, W_REG;
  wire         FILE_RE, FILE_WE, FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C;
  wire         STATUS_TO, STATUS_PD, WDT_CLEAR, STACK_PUSH, SOFT_RESET, CYCLE_END;
  wire  [4:0]  flags = {FLAG_N, FLAG_OV, FLAG_Z, FLAG_DC, FLAG_C};
  int          n_mismatch = 0;
  int          checked = 0;
  logic [20:0] pc = 21'h0;

  mise_core #(.PC_W(21)) u_dut (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
    .BANK_SELECT(BANK_SELECT), .EXT_SET_EN(EXT_SET_EN), .INDEX_BASE(INDEX_BASE),
    .FILE_RDATA(FILE_RDATA), .PROG_ADDR(PROG_ADDR), .FILE_ADDR(FILE_ADDR), .FILE_RE(FILE_RE),
    .FILE_WE(FILE_WE), .FILE_WDATA(FILE_WDATA), .W_REG(W_REG), .FLAG_N(FLAG_N), .FLAG_OV(FLAG_OV),
    .FLAG_Z(FLAG_Z), .FLAG_DC(FLAG_DC), .FLAG_C(FLAG_C), .STATUS_TO(STATUS_TO), .STATUS_PD(STATUS_PD),
    .WDT_CLEAR(WDT_CLEAR), .STACK_PUSH(STACK_PUSH), .STACK_DATA(STACK_DATA),
    .SOFT_RESET(SOFT_RESET), .CYCLE_END(CYCLE_END)
  );

  // 100 ns clock
  always #50 CLK_SYS = ~CLK_SYS;

  // compare and count
  task chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // run one instruction cycle, track the expected program address
  task ex(input logic [15:0] i, input logic [7:0] rd);
    INSTR = i;
    FILE_RDATA = rd;
    INSTR_VALID = 1'b1;
    pc = pc + 21'h2;
    if (i[15:11] == `MISE_OP_REL_CALL)
      pc = pc + {{9{i[10]}}, i[10:0], 1'b0};
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk(PROG_ADDR, pc);
  endtask

  // literal subtract and or, flag boundaries
  task t_literal;
    ex({`MISE_OP_SUB_LIT, 8'h02}, 8'h00);
    chk({W_REG, flags}, 13'h0043);
    ex({`MISE_OP_SUB_LIT, 8'h02}, 8'h00);
    chk({W_REG, flags}, 13'h0007);
    ex({`MISE_OP_OR_LIT, 8'h03}, 8'h00);
    chk({W_REG, flags}, 13'h0063);
    ex({`MISE_OP_SUB_LIT, 8'h02}, 8'h00);
    chk({W_REG, flags}, 13'h1ff0);
    ex({`MISE_OP_SUB_LIT, 8'h7f}, 8'h00);
    chk({W_REG, flags}, 13'h101a);
  endtask

  // register or and subtract, all addressing modes
  task t_register;
    BANK_SELECT = 4'h2;
    ex({`MISE_OP_OR_REG, 2'b11, 8'h13}, 8'h13);
    chk(FILE_ADDR, 12'h213);
    chk({FILE_WE, FILE_WDATA, W_REG}, 17'h19380);
    chk(flags, 5'h1a);
    ex({`MISE_OP_OR_REG, 2'b00, 8'h91}, 8'h13);
    chk(FILE_ADDR, 12'hf91);
    chk({FILE_WE, W_REG}, 9'h093);
    EXT_SET_EN = 1'b1;
    INDEX_BASE = 12'h100;
    ex({`MISE_OP_SUB_REG, 2'b10, 8'h20}, 8'h93);
    chk(FILE_ADDR, 12'h120);
    chk({FILE_WE, FILE_WDATA, W_REG, flags}, 22'h201267);
    EXT_SET_EN = 1'b0;
    ex({`MISE_OP_SUB_REG, 2'b00, 8'h20}, 8'h01);
    chk(FILE_ADDR, 12'h020);
    chk({FILE_WE, W_REG, flags}, 14'h0dc0);
    EXT_SET_EN = 1'b1;
    ex({`MISE_OP_OR_REG, 2'b00, 8'h60}, 8'h01);
    chk(FILE_ADDR, 12'h060);
    chk(W_REG, 8'h6f);
  endtask

  // register clear, banked and indexed
  task t_clear;
    BANK_SELECT = 4'h3;
    ex({`MISE_OP_CLR_REG, 1'b1, 8'h44}, 8'h00);
    chk(FILE_ADDR, 12'h344);
    chk({FILE_WE, FILE_WDATA, flags}, 14'h2004);
    ex({`MISE_OP_CLR_REG, 1'b0, 8'h5f}, 8'h00);
    chk(FILE_ADDR, 12'h15f);
  endtask

  // watchdog clear pulse and status bits
  task t_wdt;
    ex(`MISE_OP_WDT_CLEAR, 8'h00);
    chk({WDT_CLEAR, STATUS_TO, STATUS_PD}, 3'b111);
  endtask

  // relative call, then the discarded instruction of the flush cycle
  task t_call(input logic [10:0] n);
    logic [20:0] ret;
    ret = pc + 21'h2;
    ex({`MISE_OP_REL_CALL, n}, 8'h00);
    chk({STACK_PUSH, STACK_DATA}, {1'b1, ret});
    INSTR = {`MISE_OP_OR_LIT, 8'hff};
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk({W_REG, PROG_ADDR}, {8'h6f, pc});
  endtask

  // software reset returns state to reset values
  task t_soft;
    INSTR = `MISE_OP_SOFT_RESET;
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk(SOFT_RESET, 1'b1);
    INSTR_VALID = 1'b0;
    repeat (2) @(posedge CLK_SYS);
    #1;
    chk({W_REG, flags, PROG_ADDR}, 34'h0);
  endtask

  // verdict and end of run
  task end_sim;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge CLK_SYS);
    #1;
    chk({STATUS_TO, STATUS_PD, W_REG}, 10'h300);
    RST_N = 1'b1;
    t_literal;
    t_register;
    t_clear;
    t_wdt;
    t_call(11'h3ff);
    t_call(11'h400);
    t_soft;
    end_sim;
  end

  // hang guard, about six times the expected run
  initial begin
    #50000;
    n_mismatch++;
    end_sim;
  end
endmodule // mise_core_test
`default_nettype wire
